//--- pkg/srap_regs.vh
// Constants of the serial register access protocol engine
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH

// ----------------------------------------------------------------
// Opcodes, length codes and header fields
// ----------------------------------------------------------------
`define SRAP_OP_READ        2'h0
`define SRAP_OP_WRITE       2'h2
`define SRAP_OP_MSB         7
`define SRAP_OP_LSB         6
`define SRAP_LEN_MSB        5
`define SRAP_LEN_LSB        4
`define SRAP_AHI_MSB        3
`define SRAP_AHI_LSB        0

// ----------------------------------------------------------------
// Reply characters
// ----------------------------------------------------------------
`define SRAP_ECHO_HDR1      8'hc1
`define SRAP_ECHO_HDR2      8'hc2
`define SRAP_BUSY           8'h4e
`define SRAP_ACK            8'h41

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define SRAP_RAM_LAST       12'h3ff
`define SRAP_ADDR_M2HW      12'h900
`define SRAP_ADDR_HW2M      12'ha00
`define SRAP_ADDR_MODE2     12'h002
`define SRAP_ADDR_TIMO      12'h05a
`define SRAP_CKSUM_BIT      3

// ----------------------------------------------------------------
// Checksum and timing
// ----------------------------------------------------------------
`define SRAP_CRC_POLY       8'h31
`define SRAP_CRC_INIT       8'h00
`define SRAP_CLK_MHZ        100
`define SRAP_TIMO_MS        320
`define SRAP_TIMO_CYC       (`SRAP_TIMO_MS * 1000 * `SRAP_CLK_MHZ)
`define SRAP_MODE2_RST      8'h00

`endif

//--- rtl/srap_engine.v
// Serial register access protocol engine, device side
// How it works
// - opcode 00 read, 10 write, others reserved
// - length code gives 1, 2, 4, 8 bytes
// - 12-bit address from header nibble and byte
// - echo c1 then c2 during header
// - read: busy bytes, ack, then data
// - payload least significant byte first
// - write: ack per byte, final ack, no busy
// - new header right after final ack
// - timeout counts from header to last byte
// - timeout drops transaction, awaits header
// - checksum byte follows data when enabled
// - crc x8+x5+x4+1 over header and data
// - bad write checksum discards the write
// - surplus bytes ignored while busy
// - byte count from length and checksum
// - low 1k is ram, rest computed/trigger
// - reads of 900h/a00h copy mirror/hardware
// - busy bytes extended until result ready
// - eight-bit bytes, msb first
// - mode register two bit 3 enables checksum
`timescale 1ns/1ps
`include "srap_regs.vh"

module srap_engine #(
   parameter [31:0] TIMO_DEF = `SRAP_TIMO_CYC
) (
   // Clock and reset
   input  wire        mclk_i,
   input  wire        reset_i,
   // Serial link pins
   input  wire        sclk_i,
   input  wire        ssel_n_i,
   input  wire        mosi_i,
   output reg         miso_o,
   output reg         miso_oe_n_o,
   // Computed register port
   output reg         calc_req_o,
   output reg  [11:0] calc_addr_o,
   input  wire        calc_done_i,
   input  wire [63:0] calc_data_i,
   // Mirror copy triggers
   output reg         m2hw_o,
   output reg         hw2m_o
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] S_HDR1 = 3'h0;
   localparam [2:0] S_HDR2 = 3'h1;
   localparam [2:0] S_WDAT = 3'h2;
   localparam [2:0] S_WCRC = 3'h3;
   localparam [2:0] S_RSYN = 3'h4;
   localparam [2:0] S_RDAT = 3'h5;
   localparam [2:0] S_RCRC = 3'h6;
   localparam [2:0] S_WSYN = 3'h7;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge finding
   // ----------------------------------------------------------------
   reg  [1:0] sclk_s_r, ssel_s_r, mosi_s_r;
   reg        sclk_d_r;
   wire       sel  = ~ssel_s_r[1];
   wire       rise = sel & sclk_s_r[1] & ~sclk_d_r;
   wire       fall = sel & ~sclk_s_r[1] & sclk_d_r;

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_s_r <= 2'h0;
         ssel_s_r <= 2'h3;
         mosi_s_r <= 2'h0;
         sclk_d_r <= 1'b0;
      end else begin
         sclk_s_r <= {sclk_s_r[0], sclk_i};
         ssel_s_r <= {ssel_s_r[0], ssel_n_i};
         mosi_s_r <= {mosi_s_r[0], mosi_i};
         sclk_d_r <= sclk_s_r[1];
      end
   end

   // ----------------------------------------------------------------
   // Register space: ram, mirror of hardware, timeout limit
   // ----------------------------------------------------------------
   reg  [7:0]  ram_r [0:1023];
   reg  [7:0]  hwcfg_r [0:15];
   reg  [7:0]  mode2_r;
   reg  [31:0] timo_lim_r;
   wire        cksum_en = mode2_r[`SRAP_CKSUM_BIT];

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   reg  [2:0]  st_r;
   reg  [2:0]  bit_r;
   reg  [7:0]  shin_r, shout_r, crc_r;
   reg  [1:0]  op_r;
   reg  [3:0]  nbytes_r, idx_r;
   reg  [11:0] addr_r;
   reg  [63:0] wbuf_r, rbuf_r;
   reg         ready_r, valid_r;
   reg  [31:0] tcnt_r;
   reg         trun_r;
   reg  [4:0]  copy_r;
   reg         copy_dir_r;
   integer     i;

   // Bitwise crc step over one byte, msb first
   function [7:0] crc_byte;
      input [7:0] c;
      input [7:0] d;
      integer k;
      reg [7:0] x;
      begin
         x = c;
         for (k = 7; k >= 0; k = k - 1) begin
            if (x[7] ^ d[k])
               x = {x[6:0], 1'b0} ^ `SRAP_CRC_POLY;
            else
               x = {x[6:0], 1'b0};
         end
         crc_byte = x;
      end
   endfunction

   wire [7:0] rx_byte  = {shin_r[6:0], mosi_s_r[1]};
   wire       byte_end = rise & (bit_r == 3'h7);
   wire [3:0] len_n    = 4'h1 << rx_byte[`SRAP_LEN_MSB:`SRAP_LEN_LSB];
   wire [11:0] full_addr = {addr_r[11:8], rx_byte};
   wire [7:0] rd_byte  = rbuf_r[7:0];
   wire [3:0] copy_idx = copy_r[3:0] - 4'h1;

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r        <= S_HDR1;
         bit_r       <= 3'h0;
         shin_r      <= 8'h00;
         shout_r     <= `SRAP_ECHO_HDR1;
         crc_r       <= `SRAP_CRC_INIT;
         op_r        <= 2'h0;
         nbytes_r    <= 4'h0;
         idx_r       <= 4'h0;
         addr_r      <= 12'h000;
         wbuf_r      <= 64'h0;
         rbuf_r      <= 64'h0;
         ready_r     <= 1'b0;
         valid_r     <= 1'b0;
         tcnt_r      <= 32'h0;
         trun_r      <= 1'b0;
         mode2_r     <= `SRAP_MODE2_RST;
         timo_lim_r  <= TIMO_DEF;
         copy_r      <= 5'h0;
         copy_dir_r  <= 1'b0;
         miso_o      <= 1'b0;
         miso_oe_n_o <= 1'b1;
         calc_req_o  <= 1'b0;
         calc_addr_o <= 12'h000;
         m2hw_o      <= 1'b0;
         hw2m_o      <= 1'b0;
      end else begin
         m2hw_o      <= 1'b0;
         hw2m_o      <= 1'b0;
         miso_oe_n_o <= ~sel;
         if (fall | (sel & ~sclk_s_r[1] & bit_r == 3'h0))
            miso_o <= shout_r[3'h7 - bit_r];
         // Mirror copy walks one byte per clock; busy until done
         if (copy_r != 5'h0) begin
            copy_r <= copy_r - 5'h1;
            if (copy_dir_r)
               hwcfg_r[copy_idx] <= ram_r[{6'h0, copy_idx}];
            else
               ram_r[{6'h0, copy_idx}] <= hwcfg_r[copy_idx];
            if (copy_r == 5'h1)
               ready_r <= 1'b1;
         end
         if (calc_req_o & calc_done_i) begin
            calc_req_o <= 1'b0;
            rbuf_r     <= calc_data_i;
            ready_r    <= 1'b1;
         end
         if (trun_r)
            tcnt_r <= tcnt_r + 32'h1;
         if (rise) begin
            shin_r <= rx_byte;
            bit_r  <= bit_r + 3'h1;
         end
         if (trun_r & (tcnt_r > timo_lim_r)) begin
            st_r    <= S_HDR1;
            trun_r  <= 1'b0;
            tcnt_r  <= 32'h0;
            bit_r   <= 3'h0;
            shout_r <= `SRAP_ECHO_HDR1;
         end else if (byte_end) begin
            case (st_r)
               S_HDR1: begin
                  op_r     <= rx_byte[`SRAP_OP_MSB:`SRAP_OP_LSB];
                  nbytes_r <= len_n;
                  addr_r   <= {rx_byte[`SRAP_AHI_MSB:`SRAP_AHI_LSB], 8'h00};
                  crc_r    <= crc_byte(`SRAP_CRC_INIT, rx_byte);
                  trun_r   <= 1'b1;
                  tcnt_r   <= 32'h0;
                  shout_r  <= `SRAP_ECHO_HDR2;
                  st_r     <= S_HDR2;
               end
               S_HDR2: begin
                  addr_r  <= full_addr;
                  crc_r   <= crc_byte(crc_r, rx_byte);
                  idx_r   <= 4'h0;
                  ready_r <= 1'b0;
                  wbuf_r  <= 64'h0;
                  if (op_r == `SRAP_OP_WRITE) begin
                     shout_r <= `SRAP_ACK;
                     st_r    <= S_WDAT;
                  end else begin
                     // Reserved codes park in sync; timeout recovers
                     shout_r <= `SRAP_BUSY;
                     st_r    <= S_RSYN;
                     if (op_r == `SRAP_OP_READ) begin
                        if (full_addr <= `SRAP_RAM_LAST) begin
                           for (i = 0; i < 8; i = i + 1)
                              rbuf_r[i*8 +: 8] <=
                                 ram_r[(full_addr + i) & 12'h3ff];
                           ready_r <= 1'b1;
                        end else if (full_addr == `SRAP_ADDR_M2HW) begin
                           copy_r     <= 5'h10;
                           copy_dir_r <= 1'b1;
                           m2hw_o     <= 1'b1;
                        end else if (full_addr == `SRAP_ADDR_HW2M) begin
                           copy_r     <= 5'h10;
                           copy_dir_r <= 1'b0;
                           hw2m_o     <= 1'b1;
                        end else begin
                           calc_req_o  <= 1'b1;
                           calc_addr_o <= full_addr;
                        end
                     end
                  end
               end
               S_WDAT: begin
                  wbuf_r[idx_r*8 +: 8] <= rx_byte;
                  crc_r   <= crc_byte(crc_r, rx_byte);
                  idx_r   <= idx_r + 4'h1;
                  shout_r <= `SRAP_ACK;
                  if (idx_r + 4'h1 == nbytes_r) begin
                     st_r    <= cksum_en ? S_WCRC : S_WSYN;
                     valid_r <= ~cksum_en;
                     if (~cksum_en)
                        trun_r <= 1'b0;
                  end
               end
               S_WCRC: begin
                  valid_r <= (rx_byte == crc_r);
                  trun_r  <= 1'b0;
                  st_r    <= S_WSYN;
               end
               S_WSYN: begin
                  // Store completes within one clock: final ack
                  if (valid_r && op_r == `SRAP_OP_WRITE) begin
                     for (i = 0; i < 8; i = i + 1)
                        if (i < nbytes_r) begin
                           if (addr_r <= `SRAP_RAM_LAST)
                              ram_r[(addr_r + i) & 12'h3ff] <=
                                 wbuf_r[i*8 +: 8];
                           if (addr_r + i == `SRAP_ADDR_MODE2)
                              mode2_r <= wbuf_r[i*8 +: 8];
                           if (addr_r + i == `SRAP_ADDR_TIMO)
                              timo_lim_r[7:0] <= wbuf_r[i*8 +: 8];
                           if (addr_r + i == `SRAP_ADDR_TIMO + 12'h1)
                              timo_lim_r[15:8] <= wbuf_r[i*8 +: 8];
                        end
                  end
                  valid_r <= 1'b0;
                  shout_r <= `SRAP_ECHO_HDR1;
                  st_r    <= S_HDR1;
               end
               S_RSYN: begin
                  // Ack goes out first, so data bytes start one byte later
                  if (ready_r) begin
                     shout_r <= `SRAP_ACK;
                     idx_r   <= 4'h0;
                     st_r    <= S_RDAT;
                  end else
                     shout_r <= `SRAP_BUSY;
               end
               S_RDAT: begin
                  if (idx_r == nbytes_r) begin
                     trun_r  <= cksum_en;
                     shout_r <= cksum_en ? crc_r : `SRAP_ECHO_HDR1;
                     st_r    <= cksum_en ? S_RCRC : S_HDR1;
                  end else begin
                     idx_r   <= idx_r + 4'h1;
                     shout_r <= rd_byte;
                     rbuf_r  <= rbuf_r >> 8;
                     crc_r   <= crc_byte(crc_r, rd_byte);
                  end
               end
               S_RCRC: begin
                  trun_r  <= 1'b0;
                  shout_r <= `SRAP_ECHO_HDR1;
                  st_r    <= S_HDR1;
               end
               default: st_r <= S_HDR1;
            endcase
         end
      end
   end

endmodule

//--- verification/srap_host.sv
// Host master model for the serial link, mode 0
`timescale 1ns/1ps
module srap_host (
   // Clock and reply
   input  wire mclk_i,
   input  wire miso_i,
   // Link drive
   output reg  sclk_o,
   output reg  ssel_n_o,
   output reg  mosi_o
);
   initial begin
      sclk_o = 1'b0;
      ssel_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      begin
         // Start off the system clock edge so the pins never race it
         #2 ssel_n_o = 1'b0;
         for (i = 7; i >= 0; i = i - 1) begin
            mosi_o = tx[i];
            #62.5 rx[i] = miso_i;
            sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
         end
         #62.5 ssel_n_o = 1'b1;
         // Released data line must not keep looking valid
         mosi_o = ~tx[0];
         repeat (410) @(posedge mclk_i);
      end
   endtask
endmodule

//--- verification/srap_props.sv
// Port assertions for the serial register access engine
`timescale 1ns/1ps
module srap_props #(
   parameter [31:0] TIMO_DEF = 32'd2000
) (
   // Clock and reset
   input wire        mclk_i,
   input wire        reset_i,
   // Link
   input wire        sclk_i,
   input wire        ssel_n_i,
   input wire        mosi_i,
   input wire        miso_o,
   input wire        miso_oe_n_o,
   // Computed register and copies
   input wire        calc_req_o,
   input wire [11:0] calc_addr_o,
   input wire        calc_done_i,
   input wire [63:0] calc_data_i,
   input wire        m2hw_o,
   input wire        hw2m_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // Select passes two sync stages and a register, so five cycles suffice
   property p_oe_idle; ssel_n_i [*5] |-> miso_oe_n_o; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("miso driven idle");
   property p_m2hw_one; m2hw_o |=> !m2hw_o; endproperty
   a_m2hw_one: assert property (p_m2hw_one) else $error("m2hw long");
   property p_hw2m_one; hw2m_o |=> !hw2m_o; endproperty
   a_hw2m_one: assert property (p_hw2m_one) else $error("hw2m long");
   property p_copy_excl; !(m2hw_o && hw2m_o); endproperty
   a_copy_excl: assert property (p_copy_excl) else $error("both copies");
   property p_copy_calc; (m2hw_o || hw2m_o) |-> !calc_req_o; endproperty
   a_copy_calc: assert property (p_copy_calc) else $error("copy evals");
   property p_calc_hold; calc_req_o && !calc_done_i |=> calc_req_o; endproperty
   a_calc_hold: assert property (p_calc_hold) else $error("req lost");
   property p_calc_end; calc_req_o && calc_done_i |=> !calc_req_o; endproperty
   a_calc_end: assert property (p_calc_end) else $error("req stuck");
   property p_calc_addr;
      calc_req_o && !calc_done_i |=> $stable(calc_addr_o);
   endproperty
   a_calc_addr: assert property (p_calc_addr) else $error("addr moved");
   property p_calc_map;
      calc_req_o |-> calc_addr_o >= 12'h400 && calc_addr_o != 12'h900
                     && calc_addr_o != 12'ha00;
   endproperty
   a_calc_map: assert property (p_calc_map) else $error("addr map");
   c_m2hw: cover property (m2hw_o);
   c_hw2m: cover property (hw2m_o);
   c_calc: cover property (calc_req_o && calc_done_i);
endmodule

bind srap_engine srap_props #(.TIMO_DEF(TIMO_DEF)) srap_props_inst (
   .mclk_i, .reset_i, .sclk_i, .ssel_n_i, .mosi_i, .miso_o,
   .miso_oe_n_o, .calc_req_o, .calc_addr_o, .calc_done_i,
   .calc_data_i, .m2hw_o, .hw2m_o);

//--- verification/tb.sv
// Self-checking bench for the serial register access engine
`timescale 1ns/1ps
`include "srap_regs.vh"
module tb;
   localparam [1:0] op_r = `SRAP_OP_READ;
   localparam [1:0] op_w = `SRAP_OP_WRITE;
   reg         mclk_i;
   reg         reset_i;
   reg         calc_done_i = 1'b0;
   reg  [63:0] calc_data_i;
   wire        sclk, ssel_n, mosi, miso, miso_oe_n, calc_req, m2hw, hw2m;
   wire [11:0] calc_addr;
   // Released reply line floats to its pull-up level
   wire        miso_line = miso_oe_n ? 1'b1 : miso;
   integer     errors, checked;
   integer     wt = 0, n_m2hw = 0, n_hw2m = 0;
   reg         crc_on;
   reg  [11:0] addr_seen;
   reg  [63:0] rd;
   reg  [7:0]  r;

   srap_engine #(.TIMO_DEF(32'd16000)) srap_engine_inst (
      .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk),
      .ssel_n_i(ssel_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_n_o(miso_oe_n), .calc_req_o(calc_req),
      .calc_addr_o(calc_addr),
      .calc_done_i(calc_done_i), .calc_data_i(calc_data_i),
      .m2hw_o(m2hw), .hw2m_o(hw2m));
   srap_host srap_host_inst (.mclk_i(mclk_i), .miso_i(miso_line),
      .sclk_o(sclk), .ssel_n_o(ssel_n), .mosi_o(mosi));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // A slow evaluator, so the busy phase has to stretch
   always @(posedge mclk_i) begin
      calc_done_i <= 1'b0;
      if (m2hw) n_m2hw <= n_m2hw + 1;
      if (hw2m) n_hw2m <= n_hw2m + 1;
      if (calc_req && !calc_done_i) begin
         wt <= wt + 1;
         if (wt == 1200) begin
            calc_done_i <= 1'b1;
            wt <= 0;
            addr_seen <= calc_addr;
         end
      end
   end
   // ----------------------------------------------------------
   // Checking and transfer tasks
   // ----------------------------------------------------------
   task check(input string nm, input [63:0] s, input [63:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("BAD %0s exp %h seen %h", nm, e, s);
         end
      end
   endtask
   function [7:0] crc8(input [7:0] c, input [7:0] d);
      integer k;
      reg [7:0] x;
      begin
         x = c ^ d;
         for (k = 0; k < 8; k = k + 1)
            x = x[7] ? {x[6:0], 1'b0} ^ `SRAP_CRC_POLY : {x[6:0], 1'b0};
         crc8 = x;
      end
   endfunction
   task sync;
      integer k;
      begin
         k = 0;
         r = `SRAP_BUSY;
         while (r === `SRAP_BUSY && k < 40) begin
            srap_host_inst.xfer(8'h00, r);
            k = k + 1;
         end
         check("sync", r, 8'h41);
      end
   endtask
   task txn(input [1:0] op, input [1:0] lc, input [11:0] a,
            input [63:0] wd, input bad);
      integer i;
      reg [7:0] c, b;
      begin
         c = `SRAP_CRC_INIT;
         rd = 64'h0;
         b = {op, lc, a[11:8]};
         srap_host_inst.xfer(b, r);
         check("hdr1", r, 8'hc1);
         c = crc8(c, b);
         srap_host_inst.xfer(a[7:0], r);
         check("hdr2", r, 8'hc2);
         c = crc8(c, a[7:0]);
         if (op[0]) begin
            srap_host_inst.xfer(8'h00, r);
            check("rsvd", r, 8'h4e);
         end else if (op[1]) begin
            for (i = 0; i < (1 << lc); i = i + 1) begin
               b = wd[8*i +: 8];
               srap_host_inst.xfer(b, r);
               check("wack", r, 8'h41);
               c = crc8(c, b);
            end
            if (crc_on) begin
               srap_host_inst.xfer(bad ? ~c : c, r);
               check("cack", r, 8'h41);
            end
            sync;
         end else begin
            sync;
            for (i = 0; i < (1 << lc); i = i + 1) begin
               srap_host_inst.xfer(8'hff, r);
               rd[8*i +: 8] = r;
               c = crc8(c, r);
            end
            if (crc_on) begin
               srap_host_inst.xfer(8'hff, r);
               check("rcrc", r, c);
            end
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      repeat (90000) @(posedge mclk_i);
      errors = errors + 1;
      report_and_stop;
   end
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      errors = 0;
      checked = 0;
      crc_on = 1'b0;
      reset_i = 1'b1;
      calc_data_i = 64'h8877665544332211;
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      txn(op_w, 2'h2, 12'h3fc, 64'hddccbbaa, 1'b0);
      txn(op_r, 2'h2, 12'h3fc, 64'h0, 1'b0);
      check("ram", rd, 64'hddccbbaa);
      txn(op_w, 2'h0, 12'h00f, 64'h77, 1'b0);
      txn(op_r, 2'h0, `SRAP_ADDR_M2HW, 64'h0, 1'b0);
      check("m2hw", n_m2hw, 64'h1);
      txn(op_w, 2'h0, 12'h00f, 64'h00, 1'b0);
      txn(op_r, 2'h0, `SRAP_ADDR_HW2M, 64'h0, 1'b0);
      check("hw2m", n_hw2m, 64'h1);
      txn(op_r, 2'h0, 12'h00f, 64'h0, 1'b0);
      check("mirror", rd, 64'h77);
      txn(op_r, 2'h3, 12'h812, 64'h0, 1'b0);
      check("calc", rd, 64'h8877665544332211);
      check("caddr", addr_seen, 64'h812);
      txn(2'h1, 2'h0, 12'h010, 64'h0, 1'b0);
      repeat (17000) @(posedge mclk_i);
      txn(op_w, 2'h0, `SRAP_ADDR_MODE2, 64'h08, 1'b0);
      crc_on = 1'b1;
      txn(op_w, 2'h1, 12'h020, 64'hbeef, 1'b0);
      txn(op_w, 2'h1, 12'h020, 64'h1234, 1'b1);
      txn(op_r, 2'h1, 12'h020, 64'h0, 1'b0);
      check("crcw", rd, 64'hbeef);
      report_and_stop;
   end
endmodule
